// File: servo_monitor_readout_responder.sv
// serial monitor-query responder: frame check, reply build and send
`timescale 1ns/10ps
`include "servo_mon_params.svh"
module servo_monitor_readout_responder
    import servo_mon_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] ctrl_mode_i,
    input wire logic [15:0] speed_rpm_i,
    input wire logic [15:0] torque_cmd_i,
    input wire logic torque_limited_i,
    input wire logic cmd_pulse_up_i,
    input wire logic cmd_pulse_dn_i,
    input wire logic fb_pulse_up_i,
    input wire logic fb_pulse_dn_i,
    input wire logic [31:0] deviation_i,
    input wire logic [31:0] in_pins_i,
    input wire logic [31:0] out_sig_i,
    input wire logic [15:0] alarm_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    input wire logic rx_end_i,
    input wire logic rx_line_err_i,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o
);
    rsp_state_t st_ff;
    rsp_state_t nxt_st;

    snapshot_if snap ();

    monitor_snapshot u_snap (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ctrl_mode_i(ctrl_mode_i),
        .speed_rpm_i(speed_rpm_i),
        .torque_cmd_i(torque_cmd_i),
        .torque_limited_i(torque_limited_i),
        .cmd_pulse_up_i(cmd_pulse_up_i),
        .cmd_pulse_dn_i(cmd_pulse_dn_i),
        .fb_pulse_up_i(fb_pulse_up_i),
        .fb_pulse_dn_i(fb_pulse_dn_i),
        .deviation_i(deviation_i),
        .in_pins_i(in_pins_i),
        .out_sig_i(out_sig_i),
        .alarm_i(alarm_i),
        .snap(snap.src)
    );

    assign snap.cnt_clr = st_ff.cnt_clr;

    always_comb begin
        logic [3:0] ev;
        logic [7:0] err;
        logic [7:0] plen;
        logic cmd_err;
        logic count_ok;
        logic stat_clr;
        logic [4:0] idx1;
        logic [4:0] last;
        logic [7:0] b;

        ev = 4'h0;
        err = 8'h00;
        plen = `LEN_ERR_ONLY;
        cmd_err = 1'b0;
        count_ok = 1'b0;
        stat_clr = 1'b0;
        idx1 = 5'h00;
        last = 5'h00;
        b = 8'h00;

        nxt_st = st_ff;
        nxt_st.cnt_clr = 1'b0;
        nxt_st.rd_data = 32'h0000_0000;

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `REG_CTRL: begin
                    nxt_st.enable = reg_wdata_i[`CTRL_EN_BIT];
                    nxt_st.cnt_clr = reg_wdata_i[`CTRL_CLR_BIT];
                    nxt_st.axis_id =
                        reg_wdata_i[`CTRL_AXIS_MSB:`CTRL_AXIS_LSB];
                end
                `REG_IRQ_MASK: nxt_st.irq_mask = reg_wdata_i[3:0];
                default: ;
            endcase
        end

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `REG_CTRL: begin
                    nxt_st.rd_data[`CTRL_EN_BIT] = st_ff.enable;
                    nxt_st.rd_data[`CTRL_AXIS_MSB:`CTRL_AXIS_LSB] =
                        st_ff.axis_id;
                end
                `REG_IRQ_STAT: begin
                    nxt_st.rd_data[3:0] = st_ff.irq_stat;
                    stat_clr = 1'b1;
                end
                `REG_IRQ_MASK: nxt_st.rd_data[3:0] = st_ff.irq_mask;
                `REG_STATE: nxt_st.rd_data = {11'h000,
                    st_ff.tx_idx,
                    st_ff.rx_cnt,
                    7'h00, st_ff.ph};
                default: ;
            endcase
        end

        unique case (st_ff.ph)
            ph_rx: begin
                if (rx_valid_i) begin
                    if (st_ff.rx_cnt == 8'h00) begin
                        nxt_st.rx_len = rx_byte_i;
                    end
                    if (st_ff.rx_cnt == 8'h01) begin
                        nxt_st.rx_axis = rx_byte_i;
                    end
                    if (st_ff.rx_cnt == 8'h02) begin
                        nxt_st.rx_cmd = rx_byte_i;
                    end
                    nxt_st.rx_sum = st_ff.rx_sum + rx_byte_i;
                    // saturate, never wrap to a legal count
                    if (st_ff.rx_cnt != 8'hFF) begin
                        nxt_st.rx_cnt = st_ff.rx_cnt + 8'h01;
                    end
                    nxt_st.rx_line_err = st_ff.rx_line_err | rx_line_err_i;
                end else if (rx_end_i && st_ff.rx_cnt != 8'h00) begin
                    nxt_st.rx_cnt = 8'h00;
                    nxt_st.rx_sum = 8'h00;
                    nxt_st.rx_line_err = 1'b0;
                    // reads: length byte 0, four bytes
                    count_ok = (st_ff.rx_cnt ==
                        8'(st_ff.rx_len + `FRAME_OVERHEAD)) &&
                        (st_ff.rx_len == `RX_LEN_READ);
                    // bad sum drops the frame unanswered
                    if (st_ff.rx_sum != 8'h00 ||
                        st_ff.rx_cnt < `HDR_BYTES) begin
                        ev[`EV_CKSUM] = 1'b1;
                    end else if (st_ff.enable &&
                                 st_ff.rx_axis == st_ff.axis_id) begin
                        // no stale bytes in a short reply
                        nxt_st.pl = '0;
                        if (!count_ok) begin
                            cmd_err = 1'b1;
                            ev[`EV_COUNT] = 1'b1;
                        end else begin
                            unique case (st_ff.rx_cmd)
                                `CMD_STATUS: begin
                                    plen = `LEN_STATUS;
                                    nxt_st.pl[0] = {6'h00, snap.mode};
                                    nxt_st.pl[1] = snap.status;
                                end
                                `CMD_CMD_CNT: begin
                                    plen = `LEN_LONG;
                                    nxt_st.pl[3:0] = snap.cmd_cnt;
                                end
                                `CMD_FB_CNT: begin
                                    plen = `LEN_LONG;
                                    nxt_st.pl[3:0] = snap.fb_cnt;
                                end
                                `CMD_SPEED: begin
                                    plen = `LEN_WORD;
                                    nxt_st.pl[1:0] = snap.speed;
                                end
                                `CMD_TORQUE: begin
                                    plen = `LEN_WORD;
                                    nxt_st.pl[1:0] = snap.torque;
                                end
                                `CMD_DEV: begin
                                    plen = `LEN_LONG;
                                    nxt_st.pl[3:0] = snap.dev;
                                end
                                `CMD_IN_SIG: begin
                                    plen = `LEN_LONG;
                                    nxt_st.pl[3:0] = snap.in_sig;
                                end
                                `CMD_OUT_SIG: begin
                                    plen = `LEN_LONG;
                                    nxt_st.pl[3:0] = snap.out_sig;
                                end
                                `CMD_STD: begin
                                    plen = `LEN_STD;
                                    nxt_st.pl[7:0] = {snap.dev,
                                        snap.torque, snap.speed};
                                end
                                `CMD_MODE_A: begin
                                    plen = `LEN_MODE_A;
                                    nxt_st.pl[11:0] = {snap.alarm,
                                        snap.out_sig, snap.in_sig,
                                        snap.status, 6'h00, snap.mode};
                                end
                                default: begin
                                    cmd_err = 1'b1;
                                    ev[`EV_CMD] = 1'b1;
                                end
                            endcase
                        end

                        err[`ERR_CMD_BIT] = cmd_err;
                        err[`ERR_LINE_BIT] = st_ff.rx_line_err;
                        err[`ERR_ANY_BIT] = cmd_err | st_ff.rx_line_err;
                        nxt_st.pl[4'(plen - `LEN_ERR_ONLY)] = err;
                        nxt_st.ph = ph_tx;
                        nxt_st.tx_len = plen;
                        nxt_st.tx_axis = st_ff.rx_axis;
                        nxt_st.tx_cmd = st_ff.rx_cmd;
                        nxt_st.tx_idx = 5'h00;
                        nxt_st.tx_byte = plen;
                        nxt_st.tx_sum = plen;
                        nxt_st.tx_valid = 1'b1;
                    end
                end
            end

            ph_tx: begin
                // incoming bytes are dropped while a reply goes out
                if (tx_ready_i) begin
                    // byte 0, the length, is already out
                    last = 5'(st_ff.tx_len + `HDR_BYTES);
                    idx1 = st_ff.tx_idx + 5'h01;
                    nxt_st.tx_idx = idx1;
                    if (st_ff.tx_idx == last) begin
                        nxt_st.tx_valid = 1'b0;
                        nxt_st.ph = ph_rx;
                        ev[`EV_DONE] = 1'b1;
                    end else if (idx1 == last) begin
                        // sum of whole reply comes to zero
                        nxt_st.tx_byte = 8'(~st_ff.tx_sum + 8'h01);
                    end else begin
                        if (idx1 == 5'h01) begin
                            b = st_ff.tx_axis;
                        end else if (idx1 == 5'h02) begin
                            b = st_ff.tx_cmd;
                        end else begin
                            b = st_ff.pl[4'(idx1 - `HDR_BYTES5)];
                        end
                        nxt_st.tx_byte = b;
                        nxt_st.tx_sum = st_ff.tx_sum + b;
                    end
                end
            end
        endcase

        // a new event in the clearing read's cycle survives
        nxt_st.irq_stat = (stat_clr ? 4'h0 : st_ff.irq_stat) | ev;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
            // axis id reads 01h until set; answers nothing until enabled
            st_ff.axis_id <= `AXIS_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs come straight from flops
    assign tx_byte_o = st_ff.tx_byte;
    assign tx_valid_o = st_ff.tx_valid;
    assign reg_rdata_o = st_ff.rd_data;
    assign irq_o = st_ff.irq;
endmodule : servo_monitor_readout_responder

// File: servo_mon_params.svh
// constants for the servo monitor readout responder
`ifndef SERVO_MON_PARAMS_SVH
`define SERVO_MON_PARAMS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_IRQ_STAT 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_STATE 8'h0C

// control register fields
`define CTRL_EN_BIT 0
`define CTRL_CLR_BIT 1
`define CTRL_AXIS_LSB 8
`define CTRL_AXIS_MSB 15
`define AXIS_RESET 8'h01

// interrupt event bits
`define EV_DONE 0
`define EV_CKSUM 1
`define EV_COUNT 2
`define EV_CMD 3

// command/mode bytes: mode in the high nibble, command in the low
`define CMD_STATUS 8'h02
`define CMD_CMD_CNT 8'h12
`define CMD_FB_CNT 8'h22
`define CMD_SPEED 8'h42
`define CMD_TORQUE 8'h52
`define CMD_DEV 8'h62
`define CMD_IN_SIG 8'h72
`define CMD_OUT_SIG 8'h82
`define CMD_STD 8'h92
`define CMD_MODE_A 8'hA2

// reply payload lengths, error code included
`define LEN_ERR_ONLY 8'h01
`define LEN_STATUS 8'h03
`define LEN_WORD 8'h03
`define LEN_LONG 8'h05
`define LEN_STD 8'h09
`define LEN_MODE_A 8'h0D

// frame overhead: length, axis, command/mode, checksum
`define FRAME_OVERHEAD 8'h04
`define HDR_BYTES 8'h03
`define HDR_BYTES5 5'h03
`define RX_LEN_READ 8'h00

// error code bits
`define ERR_ANY_BIT 7
`define ERR_CMD_BIT 5
`define ERR_LINE_BIT 4

// status byte bits
`define ST_CCW_TRQ 5
`define ST_CW_TRQ 4
`define ST_CCW_RUN 3
`define ST_CW_RUN 2
`define ST_BRAKE 1
`define ST_TRQ_LIM 0

// braking permitted below this speed, r/min (30)
`define BRAKE_SPEED_RPM 16'h001E

// input bits that read 1 while the input is open
// bit0 cw over-travel, bit1 ccw over-travel, bit2 zero clamp,
// bit3 pulse inhibit
`define IN_OPEN_HIGH_MASK 32'h0000_000F

`endif

// File: servo_mon_pkg.sv
// types shared by the servo monitor readout responder
package servo_mon_pkg;

    typedef enum logic [0:0] {
        ph_rx = 1'b0,
        ph_tx = 1'b1
    } phase_t;

    typedef struct packed {
        phase_t ph;
        logic [7:0] rx_cnt;
        logic [7:0] rx_len;
        logic [7:0] rx_axis;
        logic [7:0] rx_cmd;
        logic [7:0] rx_sum;
        logic rx_line_err;
        logic [7:0] tx_len;
        logic [7:0] tx_axis;
        logic [7:0] tx_cmd;
        logic [12:0][7:0] pl;
        logic [4:0] tx_idx;
        logic [7:0] tx_sum;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic enable;
        logic [7:0] axis_id;
        logic cnt_clr;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        logic [31:0] rd_data;
    } rsp_state_t;

    typedef struct packed {
        logic [31:0] s1;
        logic [31:0] s2;
        logic [31:0] s3;
        logic [31:0] in_sig;
        logic [31:0] cmd_cnt;
        logic [31:0] fb_cnt;
        logic [7:0] status;
        logic [1:0] mode;
        logic [15:0] speed;
        logic [15:0] torque;
        logic [31:0] dev;
        logic [31:0] out_sig;
        logic [15:0] alarm;
    } mon_state_t;

endpackage : servo_mon_pkg

// File: snapshot_if.sv
// monitor snapshot carried from the sampler to the responder
`timescale 1ns/10ps
interface snapshot_if;
    logic [1:0] mode;
    logic [7:0] status;
    logic [31:0] cmd_cnt;
    logic [31:0] fb_cnt;
    logic [15:0] speed;
    logic [15:0] torque;
    logic [31:0] dev;
    logic [31:0] in_sig;
    logic [31:0] out_sig;
    logic [15:0] alarm;
    logic cnt_clr;

    modport src (
        output mode, status, cmd_cnt, fb_cnt, speed, torque, dev,
        output in_sig, out_sig, alarm,
        input cnt_clr
    );
    modport dst (
        input mode, status, cmd_cnt, fb_cnt, speed, torque, dev,
        input in_sig, out_sig, alarm,
        output cnt_clr
    );
endinterface : snapshot_if

// File: monitor_snapshot.sv
// samples drive state into status byte, counters and input signals
`timescale 1ns/10ps
`include "servo_mon_params.svh"
module monitor_snapshot
    import servo_mon_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] ctrl_mode_i,
    input wire logic [15:0] speed_rpm_i,
    input wire logic [15:0] torque_cmd_i,
    input wire logic torque_limited_i,
    input wire logic cmd_pulse_up_i,
    input wire logic cmd_pulse_dn_i,
    input wire logic fb_pulse_up_i,
    input wire logic fb_pulse_dn_i,
    input wire logic [31:0] deviation_i,
    input wire logic [31:0] in_pins_i,
    input wire logic [31:0] out_sig_i,
    input wire logic [15:0] alarm_i,
    snapshot_if.src snap
);
    mon_state_t st_ff;
    mon_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = in_pins_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.in_sig = st_ff.s3 ^ `IN_OPEN_HIGH_MASK;
        end
        nxt_st.mode = ctrl_mode_i;
        if (snap.cnt_clr) begin
            nxt_st.cmd_cnt = 32'h0000_0000;
        end else if (cmd_pulse_up_i && !cmd_pulse_dn_i) begin
            nxt_st.cmd_cnt = st_ff.cmd_cnt + 32'h0000_0001;
        end else if (cmd_pulse_dn_i && !cmd_pulse_up_i) begin
            nxt_st.cmd_cnt = st_ff.cmd_cnt - 32'h0000_0001;
        end
        if (snap.cnt_clr) begin
            nxt_st.fb_cnt = 32'h0000_0000;
        end else if (fb_pulse_up_i && !fb_pulse_dn_i) begin
            nxt_st.fb_cnt = st_ff.fb_cnt + 32'h0000_0001;
        end else if (fb_pulse_dn_i && !fb_pulse_up_i) begin
            nxt_st.fb_cnt = st_ff.fb_cnt - 32'h0000_0001;
        end
        nxt_st.status = 8'h00;
        nxt_st.status[`ST_CCW_TRQ] = $signed(torque_cmd_i) > 16'sh0000;
        nxt_st.status[`ST_CW_TRQ] = $signed(torque_cmd_i) < 16'sh0000;
        nxt_st.status[`ST_CCW_RUN] = $signed(speed_rpm_i) > 16'sh0000;
        nxt_st.status[`ST_CW_RUN] = $signed(speed_rpm_i) < 16'sh0000;
        nxt_st.status[`ST_BRAKE] =
            ($signed(speed_rpm_i) < $signed(`BRAKE_SPEED_RPM)) &&
            ($signed(speed_rpm_i) > -$signed(`BRAKE_SPEED_RPM));
        nxt_st.status[`ST_TRQ_LIM] = torque_limited_i;
        nxt_st.speed = speed_rpm_i;
        nxt_st.torque = torque_cmd_i;
        nxt_st.dev = deviation_i;
        nxt_st.out_sig = out_sig_i;
        nxt_st.alarm = alarm_i;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign snap.mode = st_ff.mode;
    assign snap.status = st_ff.status;
    assign snap.cmd_cnt = st_ff.cmd_cnt;
    assign snap.fb_cnt = st_ff.fb_cnt;
    assign snap.speed = st_ff.speed;
    assign snap.torque = st_ff.torque;
    assign snap.dev = st_ff.dev;
    assign snap.in_sig = st_ff.in_sig;
    assign snap.out_sig = st_ff.out_sig;
    assign snap.alarm = st_ff.alarm;
endmodule : monitor_snapshot

// File: servo_mon_host.sv
// host model: sends query frames and collects the replies
`timescale 1ns/10ps
module servo_mon_host (
    input wire logic clk_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic rx_end_o,
    output logic rx_line_err_o,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    initial begin
        rx_byte_o = 8'h5A;
        rx_valid_o = 1'b0;
        rx_end_o = 1'b0;
        rx_line_err_o = 1'b0;
        tx_ready_o = 1'b0;
    end

    // bad flips checksum bits; slow makes the sink stall every other cycle
    task automatic xfer(input logic [7:0] f[$], input logic [7:0] bad,
        input int err_at, input bit slow, output logic [7:0] r[$]);
        logic [7:0] s;
        logic [7:0] bt;
        logic tk;
        s = 8'h00;
        r = {};
        // trailing checksum brings the frame sum to zero
        foreach (f[i]) s = s - f[i];
        f.push_back(s ^ bad);
        foreach (f[i]) begin
            @(posedge clk_i);
            rx_byte_o <= f[i];
            rx_valid_o <= 1'b1;
            rx_line_err_o <= (i == err_at);
        end
        @(posedge clk_i);
        // released line shows the inverse, not the last byte
        rx_byte_o <= ~f[f.size() - 1];
        rx_valid_o <= 1'b0;
        rx_line_err_o <= 1'b0;
        rx_end_o <= 1'b1;
        @(posedge clk_i);
        rx_end_o <= 1'b0;
        for (int n = 0; n < 100; n++) begin
            // sample before the taking edge
            @(negedge clk_i);
            tk = tx_valid_i && tx_ready_o;
            bt = tx_byte_i;
            @(posedge clk_i);
            if (tk) r.push_back(bt);
            if (r.size() > 0 && r.size() == r[0] + 4) break;
            tx_ready_o <= slow ? n[0] : 1'b1;
        end
        tx_ready_o <= 1'b0;
    endtask : xfer
endmodule : servo_mon_host

// File: servo_monitor_readout_responder_assertions.sv
// port checker for the servo monitor readout responder
`timescale 1ns/10ps
module servo_monitor_readout_responder_assertions (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic rx_end_i,
    input wire logic [7:0] tx_byte_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_rd_unmapped: assert property (reg_rd_i && !(reg_addr_i inside
        {8'h00, 8'h04, 8'h08, 8'h0C}) |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_clear_zero: assert property (reg_rd_i && reg_addr_i == 8'h00
        |=> reg_rdata_o[1] == 1'b0 && reg_rdata_o[31:16] == 16'h0)
        else $error("control read shows clear bit or high bits");
    a_event_width: assert property (reg_rd_i && reg_addr_i inside
        {8'h04, 8'h08} |=> reg_rdata_o[31:4] == 28'h0)
        else $error("event register wider than four bits");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i
        |=> tx_valid_o && $stable(tx_byte_o))
        else $error("reply byte changed before taken");
    a_tx_start: assert property ($rose(tx_valid_o) |-> $past(rx_end_i))
        else $error("reply began without frame end");
    a_tx_len: assert property ($rose(tx_valid_o) |-> tx_byte_o inside
        {8'h01, 8'h03, 8'h05, 8'h09, 8'h0D})
        else $error("reply length byte illegal");
    a_tx_release: assert property ($fell(tx_valid_o) |-> $past(tx_ready_i))
        else $error("reply byte dropped untaken");

    c_reply: cover property ($rose(tx_valid_o));
    c_stall: cover property (tx_valid_o && !tx_ready_i);
    c_irq: cover property ($rose(irq_o));
endmodule : servo_monitor_readout_responder_assertions

bind servo_monitor_readout_responder
    servo_monitor_readout_responder_assertions u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .rx_end_i(rx_end_i),
    .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

// File: servo_monitor_readout_responder_test.sv
// testbench for the servo monitor readout responder
`timescale 1ns/10ps
module servo_monitor_readout_responder_test;
    logic clk = 1'b0, rst = 1'b1, lim = 1'b0, cu = 1'b0, cd = 1'b0;
    logic fu = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rxv, rxe, rxl, txv, txr;
    logic irq, fd = 1'b0;
    logic [1:0] mode = 2'b00;
    logic [15:0] spd = 16'h0000, trq = 16'h0000, alm = 16'hA5C3;
    logic [31:0] dev = 32'h0, pins = 32'h0000_00F0, outs = 32'h1234_5678;
    logic [31:0] wdata = 32'h0, rdat, d;
    logic [7:0] addr = 8'h00, rxb, txb;
    logic [7:0] r[$];
    int err_total = 0, total_checks = 0;
    logic [15:0] sp[4] = '{16'h001D, 16'hFFE2, 16'h001E, 16'hFFE3};
    logic [15:0] tq[4] = '{16'h07D0, 16'hFFFF, 16'h0000, 16'h8000};
    logic [7:0] st[4] = '{8'h2A, 8'h15, 8'h08, 8'h17};
    logic [7:0] cm[5] = '{8'h42, 8'h52, 8'h62, 8'h72, 8'h82};
    logic [31:0] ex[5] = '{32'h0000_FED4, 32'h0000_07D0, 32'h8000_0001,
        32'h0000_00FF, 32'h1234_5678};

    always #4 clk = ~clk;

    servo_monitor_readout_responder u_dut (.core_clk_i(clk), .rst_i(rst),
        .ctrl_mode_i(mode), .speed_rpm_i(spd), .torque_cmd_i(trq),
        .torque_limited_i(lim), .cmd_pulse_up_i(cu), .cmd_pulse_dn_i(cd),
        .fb_pulse_up_i(fu), .fb_pulse_dn_i(fd), .deviation_i(dev),
        .in_pins_i(pins), .out_sig_i(outs), .alarm_i(alm),
        .rx_byte_i(rxb), .rx_valid_i(rxv), .rx_end_i(rxe),
        .rx_line_err_i(rxl), .tx_byte_o(txb), .tx_valid_o(txv),
        .tx_ready_i(txr), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat),
        .irq_o(irq));

    servo_mon_host u_host (.clk_i(clk), .rx_byte_o(rxb), .rx_valid_o(rxv),
        .rx_end_o(rxe), .rx_line_err_o(rxl), .tx_byte_i(txb),
        .tx_valid_i(txv), .tx_ready_o(txr));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdat;
    endtask : rd

    task automatic ask(input logic [7:0] c, input bit slow);
        u_host.xfer('{8'h00, 8'h01, c}, 8'h00, -1, slow, r);
    endtask : ask

    task automatic reply(input logic [7:0] len, c, err);
        logic [7:0] s;
        s = 8'h00;
        foreach (r[i]) s = s + r[i];
        chk(r.size(), len + 4);
        chk(r[0], len);
        chk(r[1], 8'h01);
        chk(r[2], c);
        chk(r[len + 2], err);
        chk(s, 8'h00);
    endtask : reply

    // little-endian field of n bytes starting at byte o of the reply
    function automatic logic [31:0] le(input int o, input int n);
        le = 32'h0;
        for (int i = n - 1; i >= 0; i--) le = {le[23:0], r[o + i]};
    endfunction : le

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, d);
        chk(d, 32'h0000_0100);
        rd(8'h08, d);
        chk(d, 32'h0);
        rd(8'h44, d);
        chk(d, 32'h0);
        rd(8'h0C, d);
        chk(d, 32'h0);
        // disabled block and foreign axis both stay silent
        ask(8'h02, 1'b0);
        chk(r.size(), 0);
        wr(8'h00, 32'h0000_0101);
        wr(8'h08, 32'h0000_000F);
        u_host.xfer('{8'h00, 8'h02, 8'h02}, 8'h00, -1, 1'b0, r);
        chk(r.size(), 0);
        for (int k = 0; k < 4; k++) begin
            mode <= k[1:0];
            spd <= sp[k];
            trq <= tq[k];
            lim <= k[0];
            ask(8'h02, k[0]);
            reply(8'h03, 8'h02, 8'h00);
            chk(r[3], k);
            chk(r[4], st[k]);
        end
        cd <= 1'b1;
        fu <= 1'b1;
        repeat (3) @(posedge clk);
        fu <= 1'b0;
        fd <= 1'b1;
        cu <= 1'b1;
        @(posedge clk);
        cd <= 1'b0;
        fd <= 1'b0;
        cu <= 1'b0;
        ask(8'h12, 1'b0);
        chk(le(3, 4), 32'hFFFF_FFFD);
        ask(8'h22, 1'b0);
        chk(le(3, 4), 32'h0000_0002);
        wr(8'h00, 32'h0000_0103);
        ask(8'h12, 1'b0);
        chk(le(3, 4), 32'h0);
        ask(8'h22, 1'b0);
        chk(le(3, 4), 32'h0);
        spd <= 16'hFED4;
        trq <= 16'h07D0;
        dev <= 32'h8000_0001;
        for (int k = 0; k < 5; k++) begin
            ask(cm[k], k[0]);
            reply((k < 2) ? 8'h03 : 8'h05, cm[k], 8'h00);
            chk(le(3, (k < 2) ? 2 : 4), ex[k]);
        end
        ask(8'h92, 1'b1);
        reply(8'h09, 8'h92, 8'h00);
        chk(le(3, 2), 32'h0000_FED4);
        chk(le(5, 2), 32'h0000_07D0);
        chk(le(7, 4), 32'h8000_0001);
        mode <= 2'b01;
        lim <= 1'b0;
        ask(8'hA2, 1'b0);
        reply(8'h0D, 8'hA2, 8'h00);
        chk(r[3], 8'h01);
        chk(r[4], 8'h24);
        chk(le(5, 4), 32'h0000_00FF);
        chk(le(9, 4), 32'h1234_5678);
        chk(le(13, 2), 32'h0000_A5C3);
        u_host.xfer('{8'h00, 8'h01, 8'h02}, 8'h00, 1, 1'b0, r);
        reply(8'h03, 8'h02, 8'h90);
        repeat (3) @(negedge clk);
        chk(irq, 1'b1);
        rd(8'h04, d);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        u_host.xfer('{8'h00, 8'h01, 8'h02}, 8'h01, -1, 1'b0, r);
        chk(r.size(), 0);
        rd(8'h04, d);
        chk(d & 32'hE, 32'h2);
        u_host.xfer('{8'h00, 8'h01, 8'h02, 8'h55}, 8'h00, -1, 1'b0, r);
        reply(8'h01, 8'h02, 8'hA0);
        rd(8'h04, d);
        chk(d & 32'hE, 32'h4);
        ask(8'hF2, 1'b0);
        reply(8'h01, 8'hF2, 8'hA0);
        rd(8'h04, d);
        chk(d & 32'hE, 32'h8);
        wr(8'h08, 32'h0);
        ask(8'h02, 1'b0);
        repeat (3) @(negedge clk);
        chk(irq, 1'b0);
        rd(8'h04, d);
        chk(d & 32'h1, 32'h1);
        report_and_stop();
    end
endmodule : servo_monitor_readout_responder_test
